// file: hdl/ito_pkg.sv
/*
  Constants, types and register map of the input terminal override logic.
  Assumes one 50 MHz clock, a synchronous active-high reset and a classic
  Wishbone slave port with 32-bit data.
*/
// Overview of operation
// - function code 50 on an input applies the stored offset to the setpoint.
// - offset is combined with the setpoint only while the offset input is on.
// - offset direction setting chooses add or subtract.
// - with the offset input off, the setpoint passes unmodified.
// - offset works whichever of the five frequency sources is selected.
// - functions are assignable to the five input slots only.
// - code 51 on forces frequency and run sources to the terminals, code 01.
// - force input off restores the configured frequency and run sources.
// - force change while driving stops the motor before the new sources apply.
// - code 52 on makes a run command act at once, skipping the start sequence.
// - ready input off means a run command goes through the normal start.
// - ready input on keeps the output stage active without a run command.
package ito_pkg;

  // ==========================================================================
  // widths and counts
  localparam int FREQ_W = 16;
  localparam int N_SLOTS = 5;
  localparam int N_FSRC = 5;
  localparam int N_RSRC = 4;
  localparam int CODE_W = 6;

  // ==========================================================================
  // input function codes and source codes
  localparam logic [CODE_W-1:0] FN_ADD = 6'h32;
  localparam logic [CODE_W-1:0] FN_FORCE = 6'h33;
  localparam logic [CODE_W-1:0] FN_READY = 6'h34;
  localparam logic [2:0] FSRC_TERMINAL = 3'h1;
  localparam logic [1:0] RSRC_TERMINAL = 2'h1;
  localparam logic [2:0] FSRC_LAST = 3'h4;

  // ==========================================================================
  // start sequence timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int START_TIME_US = 10;
  localparam int START_CYC = (START_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CYC - 1);

  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_SLOTS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_SETPT = 8'h10;
  // control field positions
  localparam int CTRL_FSRC_LSB = 0;
  localparam int CTRL_RSRC_LSB = 4;
  localparam int CTRL_DIR_BIT = 8;
  // reset values and the saturation ceiling
  localparam logic [2:0] FSRC_RESET = 3'h0;
  localparam logic [1:0] RSRC_RESET = 2'h2;
  localparam logic [FREQ_W-1:0] OFFSET_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] SLOT_RESET = 6'h00;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hFFFF;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    ST_STOPPED = 4'h1,
    ST_STARTING = 4'h2,
    ST_RUNNING = 4'h4,
    ST_STOPPING = 4'h8
  } ito_state_t;

  typedef logic [N_SLOTS-1:0][CODE_W-1:0] ito_slots_t;

  // setpoints of the five frequency sources and the run requests per run source
  typedef struct packed {
    logic [N_FSRC-1:0][FREQ_W-1:0] freq;
    logic [N_RSRC-1:0] run_req;
  } ito_src_t;

  // decoded input functions
  typedef struct packed {
    logic add_on;
    logic force_on;
    logic ready_on;
  } ito_fn_t;

endpackage : ito_pkg

// file: hdl/ito_slot_decode.sv
/*
  Decoder of the five programmable input slots into function levels.
  Assumes terminal inputs synchronous to core_clk and slot codes held stable
  by the register file.
*/
`timescale 1ns/1ps
module ito_slot_decode
  import ito_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // terminals and slot codes
  input wire logic [N_SLOTS-1:0] term_in,
  input wire ito_slots_t slot_code,
  // decoded functions
  output ito_fn_t fn
);

  typedef struct packed {
    ito_fn_t fn;
  } ito_dec_state_t;

  ito_dec_state_t st;
  ito_dec_state_t next_st;
  logic [N_SLOTS-1:0] hit_add;
  logic [N_SLOTS-1:0] hit_force;
  logic [N_SLOTS-1:0] hit_ready;

  // ==========================================================================
  // per-slot match: a function is live only if a slot carries its code
  for (genvar i = 0; i < N_SLOTS; i++) begin : g_slot
    assign hit_add[i] = term_in[i] && (slot_code[i] == FN_ADD);
    assign hit_force[i] = term_in[i] && (slot_code[i] == FN_FORCE);
    assign hit_ready[i] = term_in[i] && (slot_code[i] == FN_READY);
  end

  // combine slots; several slots with one code behave as a wired or
  always_comb begin
    next_st = st;
    next_st.fn.add_on = |hit_add;
    next_st.fn.force_on = |hit_force;
    next_st.fn.ready_on = |hit_ready;
  end

  // sampled each cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fn = st.fn;

  AST_DEC_ADD: assert property (@(posedge core_clk) disable iff (srst)
    |hit_add |=> fn.add_on) else $error("add level not decoded");

endmodule : ito_slot_decode

// file: hdl/ito_override.sv
/*
  Input terminal override logic: offset frequency, forced terminal sources
  and ready mode, with a Wishbone register file.
  Assumes a classic Wishbone master, terminal inputs synchronous to core_clk,
  and a downstream motor loop that reports when the motor has stopped.
*/
`timescale 1ns/1ps
module ito_override
  import ito_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // intelligent input terminals and sources
  input wire logic [N_SLOTS-1:0] term_in,
  input wire ito_src_t src,
  input wire logic motor_stopped,
  // to the motor control loop
  output logic [FREQ_W-1:0] freq_setpoint,
  output logic [2:0] freq_src_eff,
  output logic [1:0] run_src_eff,
  output logic motor_run,
  output logic stage_enable
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0] fsrc_sel;
    logic [1:0] rsrc_sel;
    logic offset_dir;
    logic [FREQ_W-1:0] offset_freq;
    ito_slots_t slots;
    logic ack;
    logic [31:0] dat;
    ito_state_t mode;
    logic [CNT_W-1:0] cnt;
    logic force_applied;
    logic [FREQ_W-1:0] freq;
    logic [2:0] fsrc;
    logic [1:0] rsrc;
    logic run;
    logic stage;
  } ito_core_state_t;

  localparam ito_core_state_t RESET_ST = '{
    fsrc_sel: FSRC_RESET,
    rsrc_sel: RSRC_RESET,
    offset_dir: 1'b0,
    offset_freq: OFFSET_RESET,
    slots: {N_SLOTS{SLOT_RESET}},
    ack: 1'b0,
    dat: 32'h0000_0000,
    mode: ST_STOPPED,
    cnt: '0,
    force_applied: 1'b0,
    freq: '0,
    fsrc: FSRC_RESET,
    rsrc: RSRC_RESET,
    run: 1'b0,
    stage: 1'b0
  };

  ito_core_state_t st;
  ito_core_state_t next_st;
  ito_fn_t fn;

  // ==========================================================================
  // slot decoder
  ito_slot_decode ito_slot_decode_inst (
    .core_clk(core_clk),
    .srst(srst),
    .term_in(term_in),
    .slot_code(st.slots),
    .fn(fn)
  );

  // merge a write under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================================
  // combinational helpers
  logic [31:0] ctrl_word;
  logic [31:0] slots_word;
  logic [31:0] status_word;
  logic [2:0] fsrc_use;
  logic [1:0] rsrc_use;
  logic [FREQ_W-1:0] base_freq;
  logic [FREQ_W:0] sum_freq;
  logic [FREQ_W-1:0] adj_freq;
  logic run_cmd;
  logic wb_req;

  // the committed force state chooses the sources, not the raw input
  always_comb begin
    fsrc_use = st.force_applied ? FSRC_TERMINAL : st.fsrc_sel;
    rsrc_use = st.force_applied ? RSRC_TERMINAL : st.rsrc_sel;
  end

  // pick the active source; codes beyond the five sources give zero
  always_comb begin
    base_freq = '0;
    if (fsrc_use <= FSRC_LAST) begin
      base_freq = src.freq[fsrc_use];
    end
    run_cmd = src.run_req[rsrc_use];
  end

  // offset with saturation so a subtraction never wraps to a high speed
  always_comb begin
    sum_freq = '0;
    adj_freq = base_freq;
    if (fn.add_on) begin
      if (st.offset_dir) begin
        sum_freq = {1'b0, base_freq} - {1'b0, st.offset_freq};
        adj_freq = sum_freq[FREQ_W] ? '0 : sum_freq[FREQ_W-1:0];
      end else begin
        sum_freq = {1'b0, base_freq} + {1'b0, st.offset_freq};
        adj_freq = sum_freq[FREQ_W] ? FREQ_MAX : sum_freq[FREQ_W-1:0];
      end
    end
  end

  // register images
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_FSRC_LSB +: 3] = st.fsrc_sel;
    ctrl_word[CTRL_RSRC_LSB +: 2] = st.rsrc_sel;
    ctrl_word[CTRL_DIR_BIT] = st.offset_dir;
    slots_word = {2'b00, st.slots};
    status_word = {19'h0_0000, st.fsrc, st.rsrc, st.mode, st.force_applied,
                   fn.ready_on, fn.force_on, fn.add_on};
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !st.ack;

  // ==========================================================================
  // next state
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    next_st = st;
    // wishbone: ack one cycle after the strobe, dropped the cycle after
    next_st.ack = wb_req;
    next_st.dat = '0;
    if (wb_req) begin
      if (wb_adr_i == ADDR_CTRL) begin
        next_st.dat = ctrl_word;
        if (wb_we_i) begin
          wv = merge(ctrl_word, wb_dat_i, wb_sel_i);
          next_st.fsrc_sel = wv[CTRL_FSRC_LSB +: 3];
          next_st.rsrc_sel = wv[CTRL_RSRC_LSB +: 2];
          next_st.offset_dir = wv[CTRL_DIR_BIT];
        end
      end else if (wb_adr_i == ADDR_OFFSET) begin
        next_st.dat = {16'h0000, st.offset_freq};
        if (wb_we_i) begin
          wv = merge({16'h0000, st.offset_freq}, wb_dat_i, wb_sel_i);
          next_st.offset_freq = wv[FREQ_W-1:0];
        end
      end else if (wb_adr_i == ADDR_SLOTS) begin
        next_st.dat = slots_word;
        if (wb_we_i) begin
          wv = merge(slots_word, wb_dat_i, wb_sel_i);
          next_st.slots = wv[N_SLOTS*CODE_W-1:0];
        end
      end else if (wb_adr_i == ADDR_STATUS) begin
        next_st.dat = status_word;
      end else if (wb_adr_i == ADDR_SETPT) begin
        next_st.dat = {16'h0000, st.freq};
      end else begin
        next_st.dat = '0;
      end
    end

    // run sequencer
    case (st.mode)
      ST_STOPPED: begin
        next_st.run = 1'b0;
        if (fn.force_on != st.force_applied) begin
          next_st.force_applied = fn.force_on; // idle: new sources apply at once
        end else if (run_cmd) begin
          if (fn.ready_on) begin
            next_st.mode = ST_RUNNING;
            next_st.run = 1'b1;
          end else begin
            next_st.mode = ST_STARTING;
            next_st.cnt = '0;
          end
        end
      end
      ST_STARTING: begin
        next_st.cnt = st.cnt + CNT_W'(1);
        if (fn.force_on != st.force_applied) begin
          next_st.mode = ST_STOPPING;
          next_st.run = 1'b0;
        end else if (!run_cmd) begin
          next_st.mode = ST_STOPPED;
        end else if (st.cnt == START_LAST) begin
          next_st.mode = ST_RUNNING;
          next_st.run = 1'b1;
        end
      end
      ST_RUNNING: begin
        if (fn.force_on != st.force_applied) begin
          next_st.mode = ST_STOPPING;
          next_st.run = 1'b0;
        end else if (!run_cmd) begin
          next_st.mode = ST_STOPPED;
          next_st.run = 1'b0;
        end
      end
      ST_STOPPING: begin
        next_st.run = 1'b0;
        if (motor_stopped) begin
          next_st.force_applied = fn.force_on;
          next_st.mode = ST_STOPPED;
        end
      end
      default: begin
        next_st.mode = ST_STOPPED;
        next_st.run = 1'b0;
      end
    endcase

    // outputs follow the inputs one cycle later
    next_st.fsrc = fsrc_use;
    next_st.rsrc = rsrc_use;
    next_st.freq = adj_freq;
    next_st.stage = next_st.run || (next_st.mode == ST_STARTING) || fn.ready_on;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign freq_setpoint = st.freq;
  assign freq_src_eff = st.fsrc;
  assign run_src_eff = st.rsrc;
  assign motor_run = st.run;
  assign stage_enable = st.stage;

  // ==========================================================================
  // checks
  sequence s_force_change;
    (fn.force_on != st.force_applied) && (st.mode == ST_RUNNING);
  endsequence

  sequence s_stop_wait;
    !motor_run throughout (st.mode == ST_STOPPING) [*1];
  endsequence

  AST_ADD_SUM: assert property (@(posedge core_clk) disable iff (srst)
    fn.add_on && !st.offset_dir && ({1'b0, base_freq} + {1'b0, st.offset_freq} <= {1'b0, FREQ_MAX})
    |=> freq_setpoint == $past(base_freq) + $past(st.offset_freq))
    else $error("offset not added");
  AST_ADD_SUB: assert property (@(posedge core_clk) disable iff (srst)
    fn.add_on && st.offset_dir && (base_freq >= st.offset_freq)
    |=> freq_setpoint == $past(base_freq) - $past(st.offset_freq))
    else $error("offset not subtracted");
  AST_ADD_OFF: assert property (@(posedge core_clk) disable iff (srst)
    !fn.add_on |=> freq_setpoint == $past(base_freq))
    else $error("setpoint modified without offset input");
  AST_NO_ADD: assert property (@(posedge core_clk) disable iff (srst)
    !fn.add_on && (base_freq != st.offset_freq + base_freq) |=> freq_setpoint == $past(base_freq))
    else $error("offset combined while disabled");
  AST_FORCE_SRC: assert property (@(posedge core_clk) disable iff (srst)
    st.force_applied |=> freq_src_eff == FSRC_TERMINAL && run_src_eff == RSRC_TERMINAL)
    else $error("forced sources not terminal");
  AST_FORCE_OFF: assert property (@(posedge core_clk) disable iff (srst)
    !st.force_applied |=> freq_src_eff == $past(st.fsrc_sel) && run_src_eff == $past(st.rsrc_sel))
    else $error("configured sources not restored");
  AST_FORCE_STOP: assert property (@(posedge core_clk) disable iff (srst)
    s_force_change |=> s_stop_wait ##0 (st.force_applied == $past(st.force_applied)))
    else $error("force applied before stop");
  AST_READY_RUN: assert property (@(posedge core_clk) disable iff (srst)
    st.mode == ST_STOPPED && fn.ready_on && run_cmd && (fn.force_on == st.force_applied)
    |=> motor_run) else $error("ready run not immediate");
  AST_NORMAL_START: assert property (@(posedge core_clk) disable iff (srst)
    st.mode == ST_STOPPED && !fn.ready_on && run_cmd && (fn.force_on == st.force_applied)
    |=> !motor_run ##1 !motor_run) else $error("start sequence skipped");
  AST_READY_STAGE: assert property (@(posedge core_clk) disable iff (srst)
    fn.ready_on |=> stage_enable) else $error("stage off while ready");
  AST_START_LEN: assert property (@(posedge core_clk) disable iff (srst)
    st.mode == ST_STARTING && st.cnt == START_LAST && run_cmd && (fn.force_on == st.force_applied)
    |=> motor_run) else $error("start sequence length wrong");

endmodule : ito_override

// file: tb/ito_ctrl_model.sv
/*
  Model of the far side: the controller driving the input terminals and
  frequency sources, plus the motor loop that reports standstill.
  Assumes bench commands change right after a core_clk rising edge.
*/
`timescale 1ns/1ps
module ito_ctrl_model
  import ito_pkg::*;
#(
  parameter int STOP_DLY = 8
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // commands from the bench
  input wire logic [N_SLOTS-1:0] term_cmd,
  input wire ito_src_t src_cmd,
  // drive state from the block
  input wire logic motor_run,
  // terminals, sources and motor feedback
  output logic [N_SLOTS-1:0] term_in,
  output ito_src_t src,
  output logic motor_stopped
);
  // ==========================================================
  // terminals registered; motor coasts STOP_DLY cycles before rest,
  // so a block that switches sources early is caught
  logic [7:0] coast;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      term_in <= '0;
      src <= '0;
      motor_stopped <= 1'b1;
      coast <= 8'h00;
    end else begin
      term_in <= term_cmd;
      src <= src_cmd;
      if (motor_run) begin
        motor_stopped <= 1'b0;
        coast <= 8'h00;
      end else if (coast < 8'(STOP_DLY)) begin
        coast <= coast + 8'h01;
      end else begin
        motor_stopped <= 1'b1;
      end
    end
  end
endmodule : ito_ctrl_model

// file: tb/tb.sv
/*
  Self-checking bench of the input terminal override logic.
  Assumes the block answers Wishbone in one cycle and starts in 500 cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  import ito_pkg::*;
  // ==========================================================
  // signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, motor_stopped, run, stage;
  logic [N_SLOTS-1:0] term_cmd = '0, term_in;
  ito_src_t src_cmd = '0, src;
  logic [FREQ_W-1:0] setpt;
  logic [2:0] fse;
  logic [1:0] rse;
  int bad_count = 0;
  int checks = 0;

  always #10 core_clk = ~core_clk;

  ito_override ito_override_inst (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .term_in(term_in), .src(src),
    .motor_stopped(motor_stopped), .freq_setpoint(setpt), .freq_src_eff(fse),
    .run_src_eff(rse), .motor_run(run), .stage_enable(stage));
  ito_ctrl_model ito_ctrl_model_inst (.core_clk(core_clk), .srst(srst),
    .term_cmd(term_cmd), .src_cmd(src_cmd), .motor_run(run), .term_in(term_in),
    .src(src), .motor_stopped(motor_stopped));

  // ==========================================================
  // bus and helper tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK(ack, 1'b1)
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'h0, q);
    `CHK(q, e)
  endtask : rd

  task automatic give_verdict;
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // scenarios
  task automatic t_reset;
    `CHK({fse, rse, run, stage}, 7'h08)
    rd(ADDR_CTRL, 32'h20);
    rd(ADDR_SLOTS, 32'h0);
    wr(8'h1C, 32'hFFFF, 4'hF);
    rd(8'h1C, 32'h0);
    wr(ADDR_OFFSET, 32'hABCD, 4'h1);
    rd(ADDR_OFFSET, 32'hCD);
  endtask : t_reset

  // every source, add and subtract, offset on and off
  task automatic t_offset;
    logic [15:0] f;
    wr(ADDR_SLOTS, 32'h34CF2, 4'hF);
    wr(ADDR_OFFSET, 32'h100, 4'hF);
    for (int i = 0; i < N_FSRC; i++) begin
      f = 16'h1000 + 16'(i) * 16'h0111;
      src_cmd.freq[i] <= f;
      wr(ADDR_CTRL, 32'h20 | i, 4'hF);
      term_cmd <= 5'h00;
      tick(4);
      `CHK(setpt, f)
      term_cmd <= 5'h01;
      tick(4);
      `CHK(setpt, f + 16'h0100)
      wr(ADDR_CTRL, 32'h120 | i, 4'hF);
      tick(3);
      `CHK(setpt, f - 16'h0100)
    end
    term_cmd <= 5'h00;
    tick(4);
    `CHK(setpt, 16'h1444)
  endtask : t_offset

  // force idle, then force while running
  task automatic t_force;
    int n;
    n = 0;
    wr(ADDR_CTRL, 32'h20, 4'hF);
    term_cmd <= 5'h02;
    tick(5);
    `CHK({fse, rse}, 5'h05)
    term_cmd <= 5'h00;
    tick(5);
    `CHK({fse, rse}, 5'h02)
    src_cmd.run_req <= 4'h4;
    tick(4);
    `CHK({stage, run}, 2'h2)
    do begin @(posedge core_clk); n++; end while (run !== 1'b1 && n < 600);
    `CHK(run, 1'b1)
    term_cmd <= 5'h02;
    tick(4);
    `CHK({run, fse}, 4'h0)
    n = 0;
    do begin @(posedge core_clk); n++; end while (fse !== 3'h1 && n < 40);
    `CHK(motor_stopped, 1'b1)
    `CHK({fse, rse}, 5'h05)
    src_cmd.run_req <= 4'h0;
    term_cmd <= 5'h00;
    tick(6);
    `CHK({fse, rse}, 5'h02)
  endtask : t_force

  task automatic t_ready;
    term_cmd <= 5'h04;
    tick(4);
    `CHK({stage, run}, 2'h2)
    src_cmd.run_req <= 4'h4;
    tick(3);
    `CHK(run, 1'b1)
    src_cmd.run_req <= 4'h0;
    term_cmd <= 5'h00;
    tick(4);
    `CHK(stage, 1'b0)
  endtask : t_ready

  // add moved to the last slot; the first slot is now unassigned
  task automatic t_slots;
    wr(ADDR_SLOTS, 32'h32034CC0, 4'hF);
    wr(ADDR_CTRL, 32'h20, 4'hF);
    rd(ADDR_SLOTS, 32'h32034CC0);
    term_cmd <= 5'h01;
    tick(4);
    `CHK(setpt, 16'h1000)
    term_cmd <= 5'h10;
    tick(4);
    `CHK(setpt, 16'h1100)
    // status image: add live, idle, configured sources
    rd(ADDR_STATUS, 32'h211);
    rd(ADDR_SETPT, 32'h1100);
    // large offset saturates instead of wrapping, both directions
    wr(ADDR_OFFSET, 32'hF000, 4'hF);
    tick(3);
    `CHK(setpt, 16'hFFFF)
    wr(ADDR_CTRL, 32'h120, 4'hF);
    tick(3);
    `CHK(setpt, 16'h0000)
  endtask : t_slots

  // ==========================================================
  // main sequence and watchdog
  initial begin
    tick(20);
    srst <= 1'b0;
    tick(1);
    t_reset();
    t_offset();
    t_force();
    t_ready();
    t_slots();
    give_verdict();
  end

  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule : tb
